// ### core/fmw_core.sv
// Operation
// RULE1: code 2BH with select low starts row window
// RULE2: four bytes follow, high data lines ignored
// RULE3: row window touches only row values
// RULE4: row window applied at next memory write
// RULE5: host keeps start row not above end
// RULE6: out of range pixel data is dropped
// RULE7: geometry 00 row clamp 219 or 175
// RULE8: geometry 01 row clamp always 175
// RULE9: geometry 11 row clamp 131 or 175
// RULE10: geometry 00 end row reset defaults
// RULE11: geometry 11 end row reset defaults
// RULE12: start row resets zero, geometry 01 end 175
// RULE13: code 2CH with select low starts memory write
// RULE14: each data write stores one 18 bit pixel
// RULE15: memory write loads pointers from window starts
// RULE16: start positions follow orientation setting
// RULE17: pointers advance after each stored pixel
// RULE18: any other command ends memory write
// RULE19: pixel stream length is unlimited
// RULE20: memory ends column 175, row per geometry
// RULE21: frame memory is never cleared by reset
// RULE22: commands accepted in every power state
// RULE23: column window applied at memory write
// RULE24: column wraps to start, row advances, overflow dropped
// RULE25: exchange and geometry sampled for clamp and default
//
// Decided for this implementation: the APB register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module fmw_core #(
  parameter logic [1:0] GEOM_INIT = fmw_pkg::GEOM_RST
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // host system interface
  input wire logic data_command_select,
  input wire logic write_strobe_n,
  input wire logic read_strobe_n,
  input wire logic [17:0] host_data,
  // frame memory write port
  output logic mem_we,
  output logic [7:0] mem_col,
  output logic [7:0] mem_row,
  output logic [17:0] mem_data
);

  // reset geometry must be a served code
  if (GEOM_INIT == 2'h2)
  begin : g_geom_check
    $error("geometry code 10 is not supported");
  end

  typedef struct packed {
    fmw_pkg::fmw_state_t state;
    logic [1:0] pcnt;
    logic [7:0] hi;
    logic [7:0] sx;
    logic [7:0] ex;
    logic [7:0] sy;
    logic [7:0] ey;
    logic [7:0] ax0;
    logic [7:0] ax1;
    logic [7:0] ay0;
    logic [7:0] ay1;
    logic [7:0] xp;
    logic [7:0] yp;
    logic done;
    logic wr_n;
    logic [1:0] geom;
    logic mv;
    logic mx;
    logic my;
    logic we;
    logic [7:0] col;
    logic [7:0] row;
    logic [17:0] pix;
    logic [31:0] rdata;
    logic [15:0] pixcnt;
  } fmw_regs_t;

  localparam fmw_regs_t RST = '{
    state: fmw_pkg::FMW_IDLE, pcnt: 2'h0, hi: 8'h00,
    sx: fmw_pkg::START_RST, ex: fmw_pkg::LIM_175,
    sy: fmw_pkg::START_RST, ey: (GEOM_INIT == fmw_pkg::GEOM_176) ? fmw_pkg::LIM_175 :
      (GEOM_INIT == fmw_pkg::GEOM_132) ? fmw_pkg::LIM_131 : fmw_pkg::LIM_219,
    ax0: 8'h00, ax1: 8'h00, ay0: 8'h00, ay1: 8'h00, xp: 8'h00, yp: 8'h00,
    done: 1'b1, wr_n: 1'b1, geom: GEOM_INIT, mv: fmw_pkg::EXCH_RST, mx: 1'b0, my: 1'b0,
    we: 1'b0, col: 8'h00, row: 8'h00, pix: 18'h00000, rdata: 32'h00000000,
    pixcnt: 16'h0000
  };

  ////////////////////////////////////////////////////////////////////////
  // limit decoding

  function automatic logic [7:0] mem_row_max(input logic [1:0] g);
    case (g)
      fmw_pkg::GEOM_176: mem_row_max = fmw_pkg::LIM_175;
      fmw_pkg::GEOM_132: mem_row_max = fmw_pkg::LIM_131;
      default: mem_row_max = fmw_pkg::LIM_219;
    endcase
  endfunction

  function automatic logic [7:0] row_max(input logic [1:0] g, input logic x);
    row_max = x ? fmw_pkg::LIM_175 : mem_row_max(g);
  endfunction

  function automatic logic [7:0] col_max(input logic [1:0] g, input logic x);
    col_max = x ? mem_row_max(g) : fmw_pkg::LIM_175;
  endfunction

  function automatic logic [7:0] clamp(input logic [15:0] v, input logic [7:0] m);
    clamp = (v > {8'h00, m}) ? m : v[7:0];
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // state

  fmw_regs_t q;
  fmw_regs_t d;
  logic wr_rise;
  logic is_cmd;
  logic is_data;
  logic x_at_end;
  logic y_at_end;
  logic in_range;
  logic [7:0] mx_addr;
  logic [7:0] my_addr;
  logic apb_wr;
  logic apb_rd_setup;
  logic mapped;
  logic sw_rst;

  assign wr_rise = !q.wr_n ? (write_strobe_n && read_strobe_n) : 1'b0; // RULE1 RULE13
  assign is_cmd = wr_rise && !data_command_select;
  assign is_data = wr_rise && data_command_select;
  assign mapped = (paddr == fmw_pkg::OFS_CTRL) || (paddr == fmw_pkg::OFS_STATUS) ||
                  (paddr == fmw_pkg::OFS_ROWWIN) || (paddr == fmw_pkg::OFS_COLWIN) ||
                  (paddr == fmw_pkg::OFS_PIXCNT);
  assign apb_wr = psel && penable && pwrite && mapped;
  assign apb_rd_setup = psel && !penable && !pwrite;
  assign sw_rst = apb_wr && (paddr == fmw_pkg::OFS_CTRL) && pwdata[fmw_pkg::CTRL_SWRST_BIT];
  assign x_at_end = q.mx ? (q.xp == q.ax0) : (q.xp == q.ax1);
  assign y_at_end = q.my ? (q.yp == q.ay0) : (q.yp == q.ay1);
  assign mx_addr = q.mv ? q.yp : q.xp;
  assign my_addr = q.mv ? q.xp : q.yp;
  assign in_range = (mx_addr <= fmw_pkg::LIM_175) && (my_addr <= mem_row_max(q.geom)); // RULE6 RULE20

  ////////////////////////////////////////////////////////////////////////
  // next state

  always_comb
  begin
    d = q;
    d.wr_n = write_strobe_n;
    d.we = 1'b0;
    // command decode, no power state gating
    if (is_cmd) // RULE22
    begin
      d.pcnt = 2'h0;
      case (host_data[7:0])
        fmw_pkg::CMD_COL_WINDOW: d.state = fmw_pkg::FMW_COL_PARAM;
        fmw_pkg::CMD_ROW_WINDOW: d.state = fmw_pkg::FMW_ROW_PARAM; // RULE1
        fmw_pkg::CMD_MEM_WRITE:
        begin
          d.state = fmw_pkg::FMW_MEM_WRITE; // RULE13
          d.ax0 = q.sx; // RULE23
          d.ax1 = q.ex; // RULE23
          d.ay0 = q.sy; // RULE4
          d.ay1 = q.ey; // RULE4
          d.xp = q.mx ? q.ex : q.sx; // RULE15 RULE16
          d.yp = q.my ? q.ey : q.sy; // RULE15 RULE16
          d.done = 1'b0;
        end
        default: d.state = fmw_pkg::FMW_IDLE; // RULE18
      endcase
    end
    else if (is_data)
    begin
      case (q.state)
        fmw_pkg::FMW_COL_PARAM, fmw_pkg::FMW_ROW_PARAM:
        begin
          d.pcnt = q.pcnt + 2'h1;
          if (!q.pcnt[0])
            d.hi = host_data[7:0]; // RULE2
          else if (q.state == fmw_pkg::FMW_ROW_PARAM) // RULE3
          begin
            if (!q.pcnt[1])
              d.sy = clamp({q.hi, host_data[7:0]}, row_max(q.geom, q.mv)); // RULE7 RULE8 RULE9 RULE25
            else
              d.ey = clamp({q.hi, host_data[7:0]}, row_max(q.geom, q.mv)); // RULE7 RULE8 RULE9 RULE25
          end
          else
          begin
            if (!q.pcnt[1])
              d.sx = clamp({q.hi, host_data[7:0]}, col_max(q.geom, q.mv));
            else
              d.ex = clamp({q.hi, host_data[7:0]}, col_max(q.geom, q.mv));
          end
          if (q.pcnt == 2'h3)
            d.state = fmw_pkg::FMW_IDLE;
        end
        fmw_pkg::FMW_MEM_WRITE:
        begin
          if (!q.done) // RULE19 RULE24
          begin
            d.we = in_range; // RULE6 RULE14
            d.col = mx_addr;
            d.row = my_addr;
            d.pix = host_data; // RULE14
            d.pixcnt = q.pixcnt + {15'h0000, in_range};
            if (x_at_end) // RULE17 RULE24
            begin
              d.xp = q.mx ? q.ax1 : q.ax0;
              if (y_at_end)
                d.done = 1'b1; // RULE24
              else
                d.yp = q.my ? q.yp - 8'h01 : q.yp + 8'h01;
            end
            else
              d.xp = q.mx ? q.xp - 8'h01 : q.xp + 8'h01; // RULE17
          end
        end
        default: d.state = q.state;
      endcase
    end
    // apb register writes
    if (apb_wr && (paddr == fmw_pkg::OFS_CTRL))
    begin
      d.geom = pwdata[fmw_pkg::CTRL_GEOM_LSB +: 2]; // RULE25
      d.mv = pwdata[fmw_pkg::CTRL_EXCH_BIT]; // RULE25
      d.mx = pwdata[fmw_pkg::CTRL_MIRX_BIT];
      d.my = pwdata[fmw_pkg::CTRL_MIRY_BIT];
    end
    if (apb_wr && (paddr == fmw_pkg::OFS_PIXCNT))
      d.pixcnt = 16'h0000;
    // software reset, frame memory untouched
    if (sw_rst) // RULE21
    begin
      d.state = fmw_pkg::FMW_IDLE;
      d.pcnt = 2'h0;
      d.done = 1'b1;
      d.sx = fmw_pkg::START_RST;
      d.sy = fmw_pkg::START_RST; // RULE12
      d.ex = col_max(d.geom, d.mv);
      d.ey = row_max(d.geom, d.mv); // RULE10 RULE11 RULE12
    end
    // read data prepared in setup phase
    if (apb_rd_setup)
    begin
      d.rdata = 32'h00000000;
      case (paddr)
        fmw_pkg::OFS_CTRL:
        begin
          d.rdata[fmw_pkg::CTRL_GEOM_LSB +: 2] = q.geom;
          d.rdata[fmw_pkg::CTRL_EXCH_BIT] = q.mv;
          d.rdata[fmw_pkg::CTRL_MIRX_BIT] = q.mx;
          d.rdata[fmw_pkg::CTRL_MIRY_BIT] = q.my;
        end
        fmw_pkg::OFS_STATUS:
        begin
          d.rdata[fmw_pkg::STAT_STATE_LSB +: 2] = q.state;
          d.rdata[fmw_pkg::STAT_DONE_BIT] = q.done;
          d.rdata[fmw_pkg::STAT_XPTR_LSB +: 8] = q.xp;
          d.rdata[fmw_pkg::STAT_YPTR_LSB +: 8] = q.yp;
        end
        fmw_pkg::OFS_ROWWIN:
        begin
          d.rdata[fmw_pkg::WIN_START_LSB +: 8] = q.sy;
          d.rdata[fmw_pkg::WIN_END_LSB +: 8] = q.ey;
        end
        fmw_pkg::OFS_COLWIN:
        begin
          d.rdata[fmw_pkg::WIN_START_LSB +: 8] = q.sx;
          d.rdata[fmw_pkg::WIN_END_LSB +: 8] = q.ex;
        end
        fmw_pkg::OFS_PIXCNT: d.rdata[15:0] = q.pixcnt;
        default: d.rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      q <= RST; // RULE10 RULE11 RULE12
    else
      q <= d;
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs

  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata = q.rdata;
  assign mem_we = q.we;
  assign mem_col = q.col;
  assign mem_row = q.row;
  assign mem_data = q.pix;

  ////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_row_cmd;
    is_cmd && (host_data[7:0] == fmw_pkg::CMD_ROW_WINDOW) && !sw_rst;
  endsequence

  sequence s_pixel;
    is_data && (q.state == fmw_pkg::FMW_MEM_WRITE) && !q.done && in_range && !sw_rst;
  endsequence

  sequence s_row_last;
    is_data && (q.state == fmw_pkg::FMW_ROW_PARAM) && (q.pcnt == 2'h3) && !sw_rst;
  endsequence

  sequence s_wrap;
    is_data && (q.state == fmw_pkg::FMW_MEM_WRITE) && !q.done && x_at_end && !sw_rst;
  endsequence

  row_cmd_seen_a: assert property (s_row_cmd |=> q.state == fmw_pkg::FMW_ROW_PARAM) // RULE1
    else $error("row window command not taken");

  row_clamp_a: assert property (s_row_last |=> q.ey <= row_max($past(q.geom), $past(q.mv))) // RULE7
    else $error("end row above clamp limit");

  row_only_a: assert property ((q.state == fmw_pkg::FMW_ROW_PARAM) && !sw_rst && !is_cmd
    |=> $stable(q.sx) && $stable(q.ex) && $stable(q.ay1)) // RULE3
    else $error("row window changed other state");

  ptr_load_a: assert property (is_cmd && (host_data[7:0] == fmw_pkg::CMD_MEM_WRITE) && !sw_rst
    |=> (q.xp == ($past(q.mx) ? q.ex : q.sx)) && (q.ay0 == q.sy) && !q.done) // RULE15
    else $error("pointers not loaded at memory write");

  pixel_store_a: assert property (s_pixel |=> mem_we && (mem_data == $past(host_data))) // RULE14
    else $error("pixel word not stored");

  range_keep_a: assert property (mem_we |-> (mem_col <= fmw_pkg::LIM_175)
    && (mem_row <= fmw_pkg::LIM_219)) // RULE6
    else $error("write outside memory range");

  stop_write_a: assert property (is_cmd && (host_data[7:0] != fmw_pkg::CMD_MEM_WRITE)
    |=> (q.state != fmw_pkg::FMW_MEM_WRITE) ##1 !mem_we) // RULE18
    else $error("memory write not ended by command");

  sw_default_a: assert property (sw_rst |=> (q.sy == 8'h00)
    && (q.ey == row_max(q.geom, q.mv)) && (q.state == fmw_pkg::FMW_IDLE)) // RULE12
    else $error("software reset row defaults wrong");

  col_wrap_a: assert property (s_wrap |=> q.xp == ($past(q.mx) ? q.ax1 : q.ax0)) // RULE24
    else $error("column pointer did not wrap");

  range_drop_a: assert property (is_data && (q.state == fmw_pkg::FMW_MEM_WRITE) // RULE6
    && !in_range |=> !mem_we)
    else $error("out of range pixel stored");

  end_drop_a: assert property (is_data && (q.state == fmw_pkg::FMW_MEM_WRITE) // RULE24
    && q.done |=> !mem_we)
    else $error("pixel stored past window end");

  read_block_a: assert property (!q.wr_n && write_strobe_n && !read_strobe_n // RULE1
    && !sw_rst |=> $stable(q.state) && !mem_we)
    else $error("write taken with read strobe low");

endmodule
`default_nettype wire

// ### core/fmw_pkg.sv
package fmw_pkg;

  // command codes
  localparam logic [7:0] CMD_COL_WINDOW = 8'h2A;
  localparam logic [7:0] CMD_ROW_WINDOW = 8'h2B;
  localparam logic [7:0] CMD_MEM_WRITE = 8'h2C;

  // pixel and coordinate widths
  localparam int PIX_W = 18;
  localparam int PTR_W = 8;

  // row and column limits
  localparam logic [7:0] LIM_219 = 8'hDB;
  localparam logic [7:0] LIM_175 = 8'hAF;
  localparam logic [7:0] LIM_131 = 8'h83;
  localparam logic [7:0] START_RST = 8'h00;

  // geometry select codes
  localparam logic [1:0] GEOM_220 = 2'h0;
  localparam logic [1:0] GEOM_176 = 2'h1;
  localparam logic [1:0] GEOM_132 = 2'h3;

  // apb register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_ROWWIN = 8'h08;
  localparam logic [7:0] OFS_COLWIN = 8'h0C;
  localparam logic [7:0] OFS_PIXCNT = 8'h10;

  // ctrl field positions
  localparam int CTRL_GEOM_LSB = 0;
  localparam int CTRL_EXCH_BIT = 2;
  localparam int CTRL_MIRX_BIT = 3;
  localparam int CTRL_MIRY_BIT = 4;
  localparam int CTRL_SWRST_BIT = 8;

  // status and window field positions
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_DONE_BIT = 4;
  localparam int STAT_XPTR_LSB = 8;
  localparam int STAT_YPTR_LSB = 16;
  localparam int WIN_START_LSB = 0;
  localparam int WIN_END_LSB = 16;

  // ctrl reset values
  localparam logic [1:0] GEOM_RST = 2'h0;
  localparam logic EXCH_RST = 1'b0;

  typedef enum logic [1:0] {
    FMW_IDLE,
    FMW_COL_PARAM,
    FMW_ROW_PARAM,
    FMW_MEM_WRITE
  } fmw_state_t;

endpackage

// ### tb/fmw_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module fmw_host_model (
  // clock
  input wire logic pclk,
  // host system interface
  output logic data_command_select,
  output logic write_strobe_n,
  output logic read_strobe_n,
  output logic [17:0] host_data
);
  initial
  begin
    data_command_select = 1'b1;
    write_strobe_n = 1'b1;
    read_strobe_n = 1'b1;
    host_data = 18'h3FFFF;
  end
  ////////////////////////////////////////////////////////////////
  // one strobed write, data held through the rising strobe
  task automatic xfer(input logic dc, input logic [17:0] d, input logic rd_n);
  begin
    @(posedge pclk);
    data_command_select <= dc;
    host_data <= d;
    read_strobe_n <= rd_n;
    write_strobe_n <= 1'b0;
    @(posedge pclk);
    write_strobe_n <= 1'b1;
    @(posedge pclk);
    host_data <= ~d;
    read_strobe_n <= 1'b1;
  end
  endtask
endmodule
`default_nettype wire

// ### tb/tb_fmw_core.sv
`timescale 1ns/1ps
`default_nettype none
module tb_fmw_core;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic dcs;
  logic wrn;
  logic rdn;
  logic [17:0] hd;
  logic mem_we;
  logic [7:0] mem_col;
  logic [7:0] mem_row;
  logic [17:0] mem_data;
  logic [31:0] rv;
  logic err;
  logic [33:0] got_q[$];
  logic [33:0] exp_q[$];
  logic [11:0] ctl [6] = '{12'h000, 12'h004, 12'h001, 12'h005, 12'h003, 12'h007};
  logic [7:0] lim [6] = '{8'hDB, 8'hAF, 8'hAF, 8'hAF, 8'h83, 8'hAF};
  int n_mismatch = 0;
  int num_checks = 0;
  int cyc = 0;

  always #12.5 pclk = ~pclk;

  fmw_core dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .data_command_select(dcs), .write_strobe_n(wrn), .read_strobe_n(rdn), .host_data(hd),
    .mem_we(mem_we), .mem_col(mem_col), .mem_row(mem_row), .mem_data(mem_data)
  );
  fmw_host_model host (
    .pclk(pclk), .data_command_select(dcs), .write_strobe_n(wrn),
    .read_strobe_n(rdn), .host_data(hd)
  );
  ////////////////////////////////////////////////////////////////
  // stored pixel capture and run limit
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (mem_we === 1'b1)
      got_q.push_back({mem_col, mem_row, mem_data});
    if (cyc == 5000)
    begin
      n_mismatch++;
      results();
    end
  end
  ////////////////////////////////////////////////////////////////
  task automatic results();
    if (n_mismatch == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk({2'b00, rv}, {2'b00, exp});
  endtask
  task automatic cmd(input logic [7:0] c);
    host.xfer(1'b0, {10'h3A5, c}, 1'b1);
  endtask
  task automatic win(input logic [7:0] c, input logic [15:0] s, input logic [15:0] e);
    cmd(c);
    host.xfer(1'b1, {10'h3A5, s[15:8]}, 1'b1);
    host.xfer(1'b1, {10'h3A5, s[7:0]}, 1'b1);
    host.xfer(1'b1, {10'h3A5, e[15:8]}, 1'b1);
    host.xfer(1'b1, {10'h3A5, e[7:0]}, 1'b1);
  endtask
  task automatic pix(input logic [17:0] d, input logic [7:0] c, input logic [7:0] r);
    host.xfer(1'b1, d, 1'b1);
    exp_q.push_back({c, r, d});
  endtask
  ////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rdc(fmw_pkg::OFS_ROWWIN, 32'h00DB0000);
    rdc(fmw_pkg::OFS_COLWIN, 32'h00AF0000);
    rdc(fmw_pkg::OFS_PIXCNT, 32'h0);
    apb(1'b0, 8'h20, 32'h0);
    chk({33'h0, err}, 34'h1);
    win(fmw_pkg::CMD_ROW_WINDOW, 16'h0001, 16'h0007);
    rdc(fmw_pkg::OFS_ROWWIN, 32'h00070001);
    rdc(fmw_pkg::OFS_COLWIN, 32'h00AF0000);
    for (int i = 0; i < 6; i++)
    begin
      apb(1'b1, fmw_pkg::OFS_CTRL, {20'h0, ctl[i]});
      win(fmw_pkg::CMD_ROW_WINDOW, 16'h0100, 16'h0123);
      rdc(fmw_pkg::OFS_ROWWIN, {8'h00, lim[i], 8'h00, lim[i]});
      apb(1'b1, fmw_pkg::OFS_CTRL, {20'h0, ctl[i] | 12'h100});
      rdc(fmw_pkg::OFS_ROWWIN, {8'h00, lim[i], 16'h0});
      rdc(fmw_pkg::OFS_CTRL, {20'h0, ctl[i]});
    end
    apb(1'b1, fmw_pkg::OFS_CTRL, 32'h0);
    win(fmw_pkg::CMD_COL_WINDOW, 16'h0002, 16'h0003);
    win(fmw_pkg::CMD_ROW_WINDOW, 16'h0004, 16'h0005);
    cmd(fmw_pkg::CMD_MEM_WRITE);
    for (int j = 0; j < 4; j++)
      pix(18'h2A5A0 + 18'(j), 8'(2 + j % 2), 8'(4 + j / 2));
    host.xfer(1'b1, 18'h15555, 1'b1);
    rdc(fmw_pkg::OFS_PIXCNT, 32'h4);
    rdc(fmw_pkg::OFS_STATUS, 32'h00050213);
    cmd(fmw_pkg::CMD_MEM_WRITE);
    host.xfer(1'b1, 18'h11111, 1'b0);
    pix(18'h1ABCD, 8'h02, 8'h04);
    cmd(8'h00);
    host.xfer(1'b1, 18'h12345, 1'b1);
    apb(1'b1, fmw_pkg::OFS_CTRL, 32'h18);
    cmd(fmw_pkg::CMD_MEM_WRITE);
    pix(18'h0F0F0, 8'h03, 8'h05);
    apb(1'b1, fmw_pkg::OFS_CTRL, 32'h04);
    cmd(fmw_pkg::CMD_MEM_WRITE);
    pix(18'h3C3C3, 8'h04, 8'h02);
    apb(1'b1, fmw_pkg::OFS_CTRL, 32'h0);
    win(fmw_pkg::CMD_ROW_WINDOW, 16'h00C8, 16'h00C8);
    apb(1'b1, fmw_pkg::OFS_CTRL, 32'h3);
    cmd(fmw_pkg::CMD_MEM_WRITE);
    host.xfer(1'b1, 18'h0AAAA, 1'b1);
    rdc(fmw_pkg::OFS_PIXCNT, 32'h7);
    repeat (4) @(posedge pclk);
    chk(34'(got_q.size()), 34'(exp_q.size()));
    foreach (exp_q[i])
      if (i < got_q.size())
        chk(got_q[i], exp_q[i]);
    results();
  end
endmodule
`default_nettype wire
